//--- src/asu_top.sv
/*
  Asynchronous serial unit: mode, prescaler, baud divider, transmitter with
  a data FIFO, receiver with parity/framing/overrun checks, port 1 pins.
  Assumes the register port and timer_tick run on clk; pins are asynchronous.
*/
`timescale 1ns/100ps
module asu_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic        wr,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  // Port 1 pins, bit 3 serial out, bit 4 serial in
  input  wire logic [7:0]  port1_pin_in,
  output logic [7:0]       port1_pin_out,
  output logic [7:0]       port1_pin_oe,
  // Alternative base clock
  input  wire logic        timer_tick,
  // Events
  output logic             tx_done_irq,
  output logic             rx_done_irq,
  output logic             rx_error_irq
);

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("asu_top: FIFO_DEPTH must be at least 2");
  end

  // ==========================================================================
  // Helpers
  function automatic logic data_par(input logic [7:0] d, input logic char8);
    return ^(char8 ? d : {1'b0, d[6:0]});
  endfunction

  function automatic logic [7:0] k_last(input logic [7:0] k);
    // Prohibited small divisors run as the smallest legal one
    return ((k < asu_pkg::BAUD_K_MIN) ? asu_pkg::BAUD_K_MIN : k) - 8'h01;
  endfunction

  function automatic logic tx_level(input asu_pkg::asu_chan_t c);
    case (c.phase)
      asu_pkg::PH_START:  return 1'b0;
      asu_pkg::PH_DATA:   return c.shift[0];
      asu_pkg::PH_PARITY: return c.par;
      default:            return 1'b1;
    endcase
  endfunction

  // ==========================================================================
  // State
  localparam int PRESCALE_WL = asu_pkg::PRESCALE_W;
  asu_pkg::asu_state_t s;
  asu_pkg::asu_state_t next_s;
  logic                tx_on;
  logic                fifo_push;
  logic                fifo_ready;
  logic                fifo_valid;
  logic                fifo_pop;
  logic [7:0]          fifo_data;

  assign tx_on     = s.mode.power && s.mode.tx_en;
  assign fifo_push = wr && addr == asu_pkg::ADDR_TX_BUF && tx_on;
  assign fifo_pop  = tx_on && s.tx.phase == asu_pkg::PH_IDLE;

  asu_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .flush     (!tx_on),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   (wdata),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always_comb begin
    logic       base_tick;
    logic       tx_half;
    logic       rx_half;
    logic       rx_in;
    logic       p;
    logic       perr;
    logic [2:0] last_idx;
    logic [3:0] sel;
    logic [PRESCALE_WL-1:0] mask;
    next_s              = s;
    base_tick           = 1'b0;
    p                   = 1'b0;
    perr                = 1'b0;
    mask                = '0;
    tx_half             = 1'b0;
    rx_half             = 1'b0;
    rx_in               = 1'b1;
    sel                 = s.prescale;
    last_idx            = s.mode.char8 ? asu_pkg::IDX_LAST8
                                       : asu_pkg::IDX_LAST7;
    next_s.tx_done_irq  = 1'b0;
    next_s.rx_done_irq  = 1'b0;
    next_s.rx_error_irq = 1'b0;
    next_s.pin_s1       = port1_pin_in;
    next_s.pin_s2       = s.pin_s1;

    // ========================================================================
    // Prescaler; a powered-down unit holds its bit clock still
    if (s.mode.power) begin
      next_s.pre_cnt = s.pre_cnt + 10'h001;
    end else begin
      next_s.pre_cnt = '0;
    end
    if (sel <= asu_pkg::PRESCALE_MAX) begin
      mask      = PRESCALE_WL'((11'h001 << sel) - 11'h001);
      base_tick = &(s.pre_cnt | ~mask);
    end else if (sel == asu_pkg::PRESCALE_TIMER) begin
      base_tick = timer_tick;
    end
    base_tick = base_tick && s.mode.power;

    // ========================================================================
    // Register writes
    if (wr) begin
      case (addr)
        asu_pkg::ADDR_PORT1_DIR:   next_s.port_dir   = wdata;
        asu_pkg::ADDR_PORT1_LATCH: next_s.port_latch = wdata;
        asu_pkg::ADDR_MODE:        next_s.mode  = asu_pkg::asu_mode_t'(wdata);
        asu_pkg::ADDR_PRESCALE:    next_s.prescale   = wdata[3:0];
        asu_pkg::ADDR_BAUD:        next_s.baud       = wdata;
        default: ;
      endcase
    end

    // ========================================================================
    // Register reads; read-clears come first so a same-cycle set wins
    if (rd) begin
      case (addr)
        asu_pkg::ADDR_PORT1_DIR:   next_s.rdata = s.port_dir;
        asu_pkg::ADDR_PORT1_LATCH: next_s.rdata =
          (s.port_dir & s.pin_s2) | (~s.port_dir & s.port_latch);
        asu_pkg::ADDR_MODE:        next_s.rdata = s.mode;
        asu_pkg::ADDR_RX_BUF: begin
          next_s.rdata   = s.rx_buf;
          next_s.rx_full = 1'b0;
        end
        asu_pkg::ADDR_RX_ERR: begin
          next_s.rdata  = {5'h00, s.rx_err};
          next_s.rx_err = 3'h0;
        end
        asu_pkg::ADDR_TX_STAT: begin
          next_s.rdata = 8'h00;
          next_s.rdata[asu_pkg::TX_STAT_BUF_BIT]   = !fifo_ready;
          next_s.rdata[asu_pkg::TX_STAT_SHIFT_BIT] =
            s.tx.phase != asu_pkg::PH_IDLE;
        end
        asu_pkg::ADDR_PRESCALE:    next_s.rdata = {4'h0, s.prescale};
        asu_pkg::ADDR_BAUD:        next_s.rdata = s.baud;
        default:                   next_s.rdata = 8'h00;
      endcase
    end

    // ========================================================================
    // Transmitter: each bit spans two divider outputs
    tx_half = base_tick && s.tx.baud_cnt == k_last(s.baud);
    if (base_tick && s.tx.phase != asu_pkg::PH_IDLE) begin
      next_s.tx.baud_cnt = tx_half ? 8'h00 : s.tx.baud_cnt + 8'h01;
      next_s.tx.half     = s.tx.half ^ tx_half;
    end
    case (s.tx.phase)
      asu_pkg::PH_IDLE: begin
        if (fifo_valid && tx_on) begin
          next_s.tx.phase    = asu_pkg::PH_START;
          next_s.tx.shift    = fifo_data;
          next_s.tx.baud_cnt = 8'h00;
          next_s.tx.half     = 1'b0;
          next_s.tx.idx      = 3'h0;
          p = data_par(fifo_data, s.mode.char8);
          case (s.mode.parity)
            asu_pkg::PAR_EVEN: next_s.tx.par = p;
            asu_pkg::PAR_ODD:  next_s.tx.par = ~p;
            default:           next_s.tx.par = 1'b0;
          endcase
        end
      end
      asu_pkg::PH_START: begin
        if (tx_half && s.tx.half) begin
          next_s.tx.phase = asu_pkg::PH_DATA;
        end
      end
      asu_pkg::PH_DATA: begin
        if (tx_half && s.tx.half) begin
          next_s.tx.shift = {1'b0, s.tx.shift[7:1]};
          next_s.tx.idx   = s.tx.idx + 3'h1;
          if (s.tx.idx == last_idx) begin
            next_s.tx.stop_left = s.mode.stop2;
            next_s.tx.phase = (s.mode.parity == asu_pkg::PAR_NONE)
                              ? asu_pkg::PH_STOP : asu_pkg::PH_PARITY;
          end
        end
      end
      asu_pkg::PH_PARITY: begin
        if (tx_half && s.tx.half) begin
          next_s.tx.phase = asu_pkg::PH_STOP;
        end
      end
      asu_pkg::PH_STOP: begin
        if (tx_half && s.tx.half) begin
          if (s.tx.stop_left) begin
            next_s.tx.stop_left = 1'b0;
          end else begin
            next_s.tx.phase    = asu_pkg::PH_IDLE;
            next_s.tx_done_irq = 1'b1;
          end
        end
      end
      default: next_s.tx.phase = asu_pkg::PH_IDLE;
    endcase
    if (!tx_on) begin
      next_s.tx = '0;
    end

    // ========================================================================
    // Receiver: start confirmed half a bit after the falling edge, then
    // every bit sampled at its centre; a second stop bit is not checked
    rx_in = (s.mode.power && s.mode.rx_en) ? s.pin_s2[asu_pkg::BIT_RXD]
                                           : 1'b1;
    next_s.rx_last = rx_in;
    rx_half = base_tick && s.rx.baud_cnt == k_last(s.baud);
    if (base_tick && s.rx.phase != asu_pkg::PH_IDLE) begin
      next_s.rx.baud_cnt = rx_half ? 8'h00 : s.rx.baud_cnt + 8'h01;
      next_s.rx.half     = s.rx.half ^ rx_half;
    end
    case (s.rx.phase)
      asu_pkg::PH_IDLE: begin
        if (s.rx_last && !rx_in) begin
          next_s.rx       = '0;
          next_s.rx.phase = asu_pkg::PH_START;
        end
      end
      asu_pkg::PH_START: begin
        if (rx_half) begin
          next_s.rx.half  = 1'b0;
          next_s.rx.phase = rx_in ? asu_pkg::PH_IDLE : asu_pkg::PH_DATA;
        end
      end
      asu_pkg::PH_DATA: begin
        if (rx_half && s.rx.half) begin
          next_s.rx.shift[s.rx.idx] = rx_in;
          next_s.rx.idx = s.rx.idx + 3'h1;
          if (s.rx.idx == last_idx) begin
            next_s.rx.phase = (s.mode.parity == asu_pkg::PAR_NONE)
                              ? asu_pkg::PH_STOP : asu_pkg::PH_PARITY;
          end
        end
      end
      asu_pkg::PH_PARITY: begin
        if (rx_half && s.rx.half) begin
          next_s.rx.par   = rx_in;
          next_s.rx.phase = asu_pkg::PH_STOP;
        end
      end
      asu_pkg::PH_STOP: begin
        if (rx_half && s.rx.half) begin
          p = data_par(s.rx.shift, s.mode.char8) ^ s.rx.par;
          case (s.mode.parity)
            asu_pkg::PAR_EVEN: perr = p;
            asu_pkg::PAR_ODD:  perr = ~p;
            default:           perr = 1'b0;
          endcase
          next_s.rx.phase = asu_pkg::PH_IDLE;
          next_s.rx_err[asu_pkg::ERR_PARITY_BIT]  |= perr;
          next_s.rx_err[asu_pkg::ERR_FRAMING_BIT] |= !rx_in;
          next_s.rx_err[asu_pkg::ERR_OVERRUN_BIT] |= s.rx_full;
          if (!s.rx_full) begin
            next_s.rx_buf  = s.rx.shift;
            next_s.rx_full = 1'b1;
          end
          if ((perr || !rx_in || s.rx_full) && !s.mode.merge) begin
            next_s.rx_error_irq = 1'b1;
          end else begin
            next_s.rx_done_irq  = 1'b1;
          end
        end
      end
      default: next_s.rx.phase = asu_pkg::PH_IDLE;
    endcase
    if (!(s.mode.power && s.mode.rx_en)) begin
      next_s.rx = '0;
    end
    if (!s.mode.power) begin
      next_s.rx_err  = 3'h0;
      next_s.rx_buf  = 8'h00;
      next_s.rx_full = 1'b0;
    end

    // ========================================================================
    // Pins: direction bit 0 enables the driver
    for (int i = 0; i < 8; i++) begin
      next_s.pin_oe[i]  = !next_s.port_dir[i];
      next_s.pin_out[i] = next_s.port_latch[i];
    end
    if (next_s.mode.tx_en) begin
      next_s.pin_out[asu_pkg::BIT_TXD] =
        next_s.mode.power ? tx_level(next_s.tx) : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s            <= '0;
      s.pin_s1     <= 8'hff;
      s.pin_s2     <= 8'hff;
      s.rx_last    <= 1'b1;
      s.port_dir   <= asu_pkg::RST_PORT1_DIR;
      s.port_latch <= asu_pkg::RST_PORT1_LATCH;
      s.mode       <= asu_pkg::asu_mode_t'(asu_pkg::RST_MODE);
      s.prescale   <= asu_pkg::RST_PRESCALE;
      s.baud       <= asu_pkg::RST_BAUD;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata         = s.rdata;
  assign port1_pin_out = s.pin_out;
  assign port1_pin_oe  = s.pin_oe;
  assign tx_done_irq   = s.tx_done_irq;
  assign rx_done_irq   = s.rx_done_irq;
  assign rx_error_irq  = s.rx_error_irq;

endmodule

//--- include/asu_pkg.sv
/*
  Shared definitions of the asynchronous serial unit: register addresses,
  field positions, reset values, frame encodings and the packed carriers.
  Assumes one clock domain and an 8-bit register port with 16-bit addresses.
*/
package asu_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [15:0] ADDR_PORT1_LATCH = 16'hff01;
  localparam logic [15:0] ADDR_PORT1_DIR   = 16'hff21;
  localparam logic [15:0] ADDR_MODE        = 16'hff50;
  localparam logic [15:0] ADDR_RX_BUF      = 16'hff52;
  localparam logic [15:0] ADDR_RX_ERR      = 16'hff53;
  localparam logic [15:0] ADDR_TX_BUF      = 16'hff54;
  localparam logic [15:0] ADDR_TX_STAT     = 16'hff55;
  localparam logic [15:0] ADDR_PRESCALE    = 16'hff56;
  localparam logic [15:0] ADDR_BAUD        = 16'hff57;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_PORT1_DIR   = 8'hff;
  localparam logic [7:0] RST_PORT1_LATCH = 8'h00;
  localparam logic [7:0] RST_MODE        = 8'h01;
  localparam logic [3:0] RST_PRESCALE    = 4'h0;
  localparam logic [7:0] RST_BAUD        = 8'hff;

  // ==========================================================================
  // Field positions
  localparam int BIT_TXD          = 3;
  localparam int BIT_RXD          = 4;
  localparam int TX_STAT_BUF_BIT  = 1;
  localparam int TX_STAT_SHIFT_BIT = 0;
  localparam int ERR_PARITY_BIT   = 2;
  localparam int ERR_FRAMING_BIT  = 1;
  localparam int ERR_OVERRUN_BIT  = 0;

  // ==========================================================================
  // Clocking and frame constants
  localparam int         PRESCALE_W     = 10;
  localparam logic [3:0] PRESCALE_MAX   = 4'ha;
  localparam logic [3:0] PRESCALE_TIMER = 4'hb;
  localparam logic [7:0] BAUD_K_MIN     = 8'h04;
  localparam logic [2:0] IDX_LAST8      = 3'h7;
  localparam logic [2:0] IDX_LAST7      = 3'h6;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } asu_parity_t;

  // Gray codes along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_START  = 3'h1,
    PH_DATA   = 3'h3,
    PH_PARITY = 3'h2,
    PH_STOP   = 3'h6
  } asu_phase_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        power;
    logic        tx_en;
    logic        rx_en;
    asu_parity_t parity;
    logic        char8;
    logic        stop2;
    logic        merge;
  } asu_mode_t;

  typedef struct packed {
    asu_phase_t  phase;
    logic        half;
    logic [7:0]  baud_cnt;
    logic [2:0]  idx;
    logic        stop_left;
    logic [7:0]  shift;
    logic        par;
  } asu_chan_t;

  typedef struct packed {
    logic [7:0]            pin_s1;
    logic [7:0]            pin_s2;
    logic [7:0]            port_dir;
    logic [7:0]            port_latch;
    asu_mode_t             mode;
    logic [3:0]            prescale;
    logic [7:0]            baud;
    logic [PRESCALE_W-1:0] pre_cnt;
    asu_chan_t             tx;
    asu_chan_t             rx;
    logic                  rx_last;
    logic [7:0]            rx_buf;
    logic                  rx_full;
    logic [2:0]            rx_err;
    logic [7:0]            rdata;
    logic [7:0]            pin_out;
    logic [7:0]            pin_oe;
    logic                  tx_done_irq;
    logic                  rx_done_irq;
    logic                  rx_error_irq;
  } asu_state_t;

endpackage

//--- src/asu_fifo.sv
/*
  Transmit data FIFO with valid/ready on both sides and a flush input.
  Assumes a single clock; the clock enable freezes all state while low.
*/
`timescale 1ns/100ps
module asu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  // Pointers wrap by overflow, so only powers of two are served
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("asu_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } asu_fifo_state_t;

  asu_fifo_state_t s;
  asu_fifo_state_t next_s;
  logic            push;
  logic            pop;

  assign in_ready  = (s.count != FULL_COUNT);
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr        = s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
      next_s.count  = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule

//--- bench/asu_top_assertions.sv
/*
  Port-level checker for asu_top, bound to every instance below.
  Assumes one clock domain with synchronous reset rst.
*/
`timescale 1ns/100ps
module asu_top_assertions #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and register port
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [15:0] addr,
  input wire logic        wr,
  input wire logic [7:0]  wdata,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // Pins and events
  input wire logic [7:0]  port1_pin_out,
  input wire logic [7:0]  port1_pin_oe,
  input wire logic        tx_done_irq,
  input wire logic        rx_done_irq,
  input wire logic        rx_error_irq
);
  // ==========================================
  // Helper counters, saturating so idle spans never wrap
  logic [7:0] dir_sh;
  logic [1:0] dir_age;
  logic [3:0] hi_cnt;
  logic [7:0] gap;
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_sh  <= 8'hff;
      dir_age <= 2'h3;
      hi_cnt  <= 4'h0;
      gap     <= 8'hff;
    end else begin
      if (ce && wr && addr == asu_pkg::ADDR_PORT1_DIR) begin
        dir_sh  <= wdata;
        dir_age <= 2'h0;
      end else if (dir_age != 2'h3) begin
        dir_age <= dir_age + 2'h1;
      end
      if (!port1_pin_out[3]) hi_cnt <= 4'h0;
      else if (hi_cnt != 4'hf) hi_cnt <= hi_cnt + 4'h1;
      if (tx_done_irq) gap <= 8'h00;
      else if (gap != 8'hff) gap <= gap + 8'h01;
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reset_vals_a: assert property (disable iff (1'b0)
    rst |=> rdata == 8'h00 && port1_pin_oe == 8'h00 && !tx_done_irq)
    else $error("outputs not cleared by reset");
  oe_follow_a: assert property (
    dir_age == 2'h3 |-> port1_pin_oe == ~dir_sh)
    else $error("pin enables differ from direction");
  mode_readback_a: assert property (
    (ce && wr && !rd && addr == asu_pkg::ADDR_MODE ##1 !wr
     ##1 ce && rd && !wr && addr == asu_pkg::ADDR_MODE)
    |=> rdata == $past(wdata, 3))
    else $error("mode register readback wrong");
  tx_pulse_a: assert property (
    tx_done_irq |=> !tx_done_irq)
    else $error("transmit done longer than one cycle");
  stop_level_a: assert property (
    tx_done_irq |-> port1_pin_out[3])
    else $error("line not at stop level at done");
  stop_length_a: assert property (
    tx_done_irq |-> hi_cnt >= 4'h7)
    else $error("stop bit shorter than one bit period");
  frame_gap_a: assert property (
    tx_done_irq |-> gap >= 8'h46)
    else $error("frames closer than minimum frame length");
  rx_pulse_a: assert property (
    rx_done_irq || rx_error_irq |=> !rx_done_irq && !rx_error_irq)
    else $error("receive event longer than one cycle");
endmodule
bind asu_top asu_top_assertions #(.FIFO_DEPTH(FIFO_DEPTH))
  asu_top_assertions_inst (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
  .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata),
  .port1_pin_out(port1_pin_out), .port1_pin_oe(port1_pin_oe),
  .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
  .rx_error_irq(rx_error_irq));

//--- bench/asu_partner.sv
/*
  Remote serial device: samples frames on its input line, sends frames.
  Assumes a fixed bit period in clk cycles, set by the bench.
*/
`timescale 1ns/100ps
module asu_partner #(
  parameter int BIT_CLKS = 8
) (
  // Clock and link
  input wire logic    clk,
  input wire logic    line_in,
  output logic        line_out,
  output logic [11:0] frame
);
  initial line_out = 1'b1;
  initial frame = 12'hfff;
  // Mid-bit sampling, start bit in frame[0]
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      frame[i] = line_in;
      repeat (BIT_CLKS) @(negedge clk);
    end
  end
  // Unused pattern bits are ones, so the line rests high after a frame
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      line_out = f[i];
      repeat (BIT_CLKS - 1) @(negedge clk);
    end
  endtask
endmodule

//--- bench/tb_asu_top.sv
/*
  Self-checking bench for asu_top with a remote serial partner.
  Assumes the package, partner and bound checker are compiled first.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_asu_top;
  localparam int K = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, p_out, p_oe, d;
  logic        txd, rxd, rxe, tx_line, rx_line;
  logic [11:0] frame;
  logic        tick = 1'b0;
  int          bad_count = 0;
  int          check_count = 0;
  int          ntx = 0;
  int          nrx = 0;
  int          nre = 0;
  // ==========================================
  // Clock, pins, design and partner
  initial forever #25 clk = ~clk;
  // Pull-up holds the link high while the pin is released
  assign tx_line = (p_oe[3] === 1'b1) ? p_out[3] : 1'b1;
  always @(negedge clk) begin
    if (txd === 1'b1) ntx++;
    if (rxd === 1'b1) nrx++;
    if (rxe === 1'b1) nre++;
  end
  asu_top asu_top_inst (
    .clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wr(wr), .wdata(wdata),
    .rd(rd), .rdata(rdata), .port1_pin_in({3'h0, rx_line, tx_line, 3'h0}),
    .port1_pin_out(p_out), .port1_pin_oe(p_oe), .timer_tick(tick),
    .tx_done_irq(txd), .rx_done_irq(rxd), .rx_error_irq(rxe));
  asu_partner #(.BIT_CLKS(2 * K)) asu_partner_inst (
    .clk(clk), .line_in(tx_line), .line_out(rx_line), .frame(frame));
  // ==========================================
  // Bus tasks and expectations
  task automatic wreg(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    `CHK(d, e)
  endtask
  function automatic logic [11:0] xf(input logic [4:0] f,
                                     input logic [7:0] v);
    logic [11:0] r;
    logic [1:0]  q;
    int          n;
    logic        p;
    r = 12'hfff;
    r[0] = 1'b0;
    q = f[4:3];
    n = f[2] ? 8 : 7;
    p = ^(f[2] ? v : {1'b0, v[6:0]});
    for (int i = 0; i < n; i++) r[1 + i] = v[i];
    if (q != 2'h0) r[1 + n] = (q != 2'h1) & (p ^ (q == 2'h2));
    return r;
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rchk(asu_pkg::ADDR_MODE, 8'h01);
    rchk(asu_pkg::ADDR_PORT1_DIR, 8'hff);
    wreg(asu_pkg::ADDR_PRESCALE, 8'h00);
    wreg(asu_pkg::ADDR_BAUD, 8'(K));
    wreg(asu_pkg::ADDR_MODE, 8'h04);
    rchk(asu_pkg::ADDR_MODE, 8'h04);
    wreg(asu_pkg::ADDR_MODE, 8'h84);
    wreg(asu_pkg::ADDR_MODE, 8'he4);
    wreg(asu_pkg::ADDR_PORT1_LATCH, 8'h08);
    wreg(asu_pkg::ADDR_PORT1_DIR, 8'hf7);
    rchk(asu_pkg::ADDR_PORT1_DIR, 8'hf7);
    `CHK(p_oe, 8'h08)
    $display("t_reset done");
  endtask
  task automatic t_frame(input logic [4:0] f, input logic [7:0] v);
    int n;
    int j;
    n = 2 + (f[2] ? 8 : 7) + int'(f[4:3] != 2'h0) + int'(f[1]);
    wreg(asu_pkg::ADDR_MODE, {3'h7, f});
    wreg(asu_pkg::ADDR_TX_BUF, v);
    for (j = 0; j < 400 && txd !== 1'b1; j++) @(negedge clk);
    `CHK(j, 1 + 2 * K * n)
    repeat (6 * K) @(negedge clk);
    `CHK(frame, xf(f, v))
    $display("t_frame done");
  endtask
  task automatic t_power_off;
    int n0;
    wreg(asu_pkg::ADDR_PORT1_LATCH, 8'h00);
    wreg(asu_pkg::ADDR_MODE, 8'he4);
    wreg(asu_pkg::ADDR_TX_BUF, 8'h0f);
    repeat (30) @(negedge clk);
    n0 = ntx;
    wreg(asu_pkg::ADDR_MODE, 8'h44);
    repeat (100) @(negedge clk);
    `CHK(p_out[3], 1'b1)
    `CHK(ntx, n0)
    rchk(asu_pkg::ADDR_TX_STAT, 8'h00);
    wreg(asu_pkg::ADDR_MODE, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(p_out[3], 1'b0)
    `CHK(p_oe[3], 1'b1)
    wreg(asu_pkg::ADDR_PORT1_LATCH, 8'h08);
    wreg(asu_pkg::ADDR_MODE, 8'h84);
    $display("t_power_off done");
  endtask
  task automatic t_fifo;
    int n0;
    n0 = ntx;
    wreg(asu_pkg::ADDR_MODE, 8'he4);
    for (int i = 0; i < 18; i++) wreg(asu_pkg::ADDR_TX_BUF, 8'(i));
    rchk(asu_pkg::ADDR_TX_STAT, 8'h03);
    for (int j = 0; j < 2000 && ntx - n0 < 17; j++) @(negedge clk);
    repeat (100) @(negedge clk);
    `CHK(ntx - n0, 17)
    `CHK(p_out[3], 1'b1)
    rchk(asu_pkg::ADDR_TX_STAT, 8'h00);
    $display("t_fifo done");
  endtask
  task automatic t_rx;
    int r0;
    int e0;
    wreg(asu_pkg::ADDR_MODE, 8'hfc);
    r0 = nrx;
    e0 = nre;
    asu_partner_inst.send(xf(5'h1c, 8'h5a));
    repeat (4) @(negedge clk);
    `CHK(nrx - r0, 1)
    `CHK(nre - e0, 0)
    rchk(asu_pkg::ADDR_RX_BUF, 8'h5a);
    asu_partner_inst.send(xf(5'h1c, 8'h3c) ^ 12'h200);
    repeat (4) @(negedge clk);
    `CHK(nre - e0, 1)
    rchk(asu_pkg::ADDR_RX_ERR, 8'h04);
    wreg(asu_pkg::ADDR_MODE, 8'hfd);
    asu_partner_inst.send(xf(5'h1c, 8'h81) ^ 12'h400);
    repeat (4) @(negedge clk);
    `CHK(nrx - r0, 2)
    `CHK(nre - e0, 1)
    rchk(asu_pkg::ADDR_RX_ERR, 8'h03);
    $display("t_rx done");
  endtask
  // ==========================================
  // Sequence, watchdog and verdict
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_frame(5'h1c, 8'h55);
    t_frame(5'h12, 8'h36);
    t_frame(5'h04, 8'h87);
    t_frame(5'h0e, 8'ha5);
    wreg(asu_pkg::ADDR_PRESCALE, 8'h0b);
    tick = 1'b1;
    t_frame(5'h02, 8'hc3);
    t_power_off;
    t_fifo;
    t_rx;
    print_verdict;
  end
  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
endmodule
